// *** hdl/line_out_mixer_charge_pump_ctrl.sv ***
// Register bank and route decode for two line-output pairs and the pump.
// Assumes an AXI4-Lite master on clk_i and level inputs synchronous to it.
`timescale 1ns/1ps
module line_out_mixer_charge_pump_ctrl (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // AXI4-Lite write address and data.
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [line_out_mixer_pkg::ADDR_W-1:0] awaddr_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  // AXI4-Lite write response.
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // AXI4-Lite read.
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [line_out_mixer_pkg::ADDR_W-1:0] araddr_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  // Level sources for the pump.
  input wire logic [5:0] hp_left_volume_i,
  input wire logic [5:0] hp_right_volume_i,
  input wire logic [5:0] audio_if_one_level_i,
  input wire logic [5:0] audio_if_two_level_i,
  // Pair one route enables and controls.
  output logic left_mix_to_pair_one_pos_o,
  output logic right_mix_to_pair_one_neg_o,
  output logic left_mix_to_pair_one_neg_o,
  output logic left_mix_diff_pair_one_o,
  output logic left_in_one_to_pair_one_o,
  output logic right_in_one_to_pair_one_o,
  output logic pair_one_single_ended_o,
  output logic pair_one_neg_mute_o,
  output logic pair_one_pos_mute_o,
  output logic pair_one_atten_o,
  // Pair two route enables and controls.
  output logic right_mix_to_pair_two_pos_o,
  output logic left_mix_to_pair_two_neg_o,
  output logic right_mix_to_pair_two_neg_o,
  output logic right_mix_diff_pair_two_o,
  output logic left_in_one_to_pair_two_o,
  output logic right_in_one_to_pair_two_o,
  output logic pair_two_single_ended_o,
  output logic pair_two_neg_mute_o,
  output logic pair_two_pos_mute_o,
  output logic pair_two_atten_o,
  // Charge pump.
  output logic pump_en_o,
  output logic pump_discharge_o,
  output logic pump_dynamic_o,
  output logic [1:0] pump_level_o,
  output logic pump_clk_o
);
  import line_out_mixer_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser.

  logic rst_meta_q;
  logic rst_n_q;

  // Assert at once, release after two edges.
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write channel handshake.

  logic aw_full_q;
  logic aw_full_d;
  logic w_full_q;
  logic w_full_d;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [ADDR_W-3:0] wr_idx_q;
  logic [15:0] wr_data_q;
  logic [1:0] wr_strb_q;
  logic do_write;
  logic wr_hit;

  // The response follows once address and data are both held.
  assign do_write = aw_full_q & w_full_q;
  assign aw_full_d = (awvalid_i & awready_q) | (aw_full_q & ~do_write);
  assign w_full_d = (wvalid_i & wready_q) | (w_full_q & ~do_write);
  assign bvalid_d = do_write | (bvalid_q & ~bready_i);

  // Handshake state; readies drop while a write is pending or answering.
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q <= ~w_full_d & ~bvalid_d;
      bvalid_q <= bvalid_d;
      if (do_write)
      begin
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Capture address and data as each is taken.
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      wr_idx_q <= '0;
      wr_data_q <= '0;
      wr_strb_q <= '0;
    end
    else
    begin
      if (awvalid_i & awready_q)
      begin
        wr_idx_q <= awaddr_i[ADDR_W-1:2];
      end
      if (wvalid_i & wready_q)
      begin
        wr_data_q <= wdata_i[15:0];
        wr_strb_q <= wstrb_i[1:0];
      end
    end
  end

  // Byte-lane merge of a write into a stored register.
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] mask);
    logic [15:0] val;
    val = old;
    if (wr_strb_q[0])
    begin
      val[7:0] = wr_data_q[7:0];
    end
    if (wr_strb_q[1])
    begin
      val[15:8] = wr_data_q[15:8];
    end
    return val & mask;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.

  logic [15:0] vol_q;
  logic [15:0] mix_one_q;
  logic [15:0] mix_two_q;
  logic [15:0] pump_en_q;
  logic [15:0] pump_disch_q;
  logic [15:0] env_q;

  assign wr_hit = (wr_idx_q == IDX_LINE_OUTPUT_VOLUME) || (wr_idx_q == IDX_LINE_MIXER_ONE)
    || (wr_idx_q == IDX_LINE_MIXER_TWO) || (wr_idx_q == IDX_PUMP_ENABLE_CTRL)
    || (wr_idx_q == IDX_PUMP_DISCHARGE_CTRL) || (wr_idx_q == IDX_ENVELOPE_TRACKING_CTRL);

  // Each register loads on a write to its own index; reserved bits stay 0.
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      vol_q <= RST_VOLUME;
      mix_one_q <= RST_MIXER;
      mix_two_q <= RST_MIXER;
      pump_en_q <= RST_PUMP_EN;
      pump_disch_q <= RST_PUMP_DISCH;
      env_q <= RST_ENVELOPE;
    end
    else if (do_write)
    begin
      if (wr_idx_q == IDX_LINE_OUTPUT_VOLUME)
      begin
        vol_q <= merge(vol_q, MASK_VOLUME);
      end
      if (wr_idx_q == IDX_LINE_MIXER_ONE)
      begin
        mix_one_q <= merge(mix_one_q, MASK_MIXER);
      end
      if (wr_idx_q == IDX_LINE_MIXER_TWO)
      begin
        mix_two_q <= merge(mix_two_q, MASK_MIXER);
      end
      if (wr_idx_q == IDX_PUMP_ENABLE_CTRL)
      begin
        pump_en_q <= merge(pump_en_q, MASK_PUMP);
      end
      if (wr_idx_q == IDX_PUMP_DISCHARGE_CTRL)
      begin
        pump_disch_q <= merge(pump_disch_q, MASK_PUMP);
      end
      if (wr_idx_q == IDX_ENVELOPE_TRACKING_CTRL)
      begin
        env_q <= merge(env_q, MASK_ENVELOPE);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel.

  logic arready_q;
  logic rvalid_q;
  logic rvalid_d;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [ADDR_W-3:0] rd_idx;
  logic ar_take;

  assign ar_take = arvalid_i & arready_q;
  assign rvalid_d = ar_take | (rvalid_q & ~rready_i);
  assign rd_idx = araddr_i[ADDR_W-1:2];

  // Data are returned the cycle after the address is taken.
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end
    else
    begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take)
      begin
        rresp_q <= RESP_OKAY;
        unique case (rd_idx)
          IDX_LINE_OUTPUT_VOLUME: rdata_q <= {16'h0000, vol_q};
          IDX_LINE_MIXER_ONE: rdata_q <= {16'h0000, mix_one_q};
          IDX_LINE_MIXER_TWO: rdata_q <= {16'h0000, mix_two_q};
          IDX_PUMP_ENABLE_CTRL: rdata_q <= {16'h0000, pump_en_q};
          IDX_PUMP_DISCHARGE_CTRL: rdata_q <= {16'h0000, pump_disch_q};
          IDX_ENVELOPE_TRACKING_CTRL: rdata_q <= {16'h0000, env_q};
          default:
          begin
            rdata_q <= '0;
            rresp_q <= RESP_SLVERR;
          end
        endcase
      end
    end
  end

  assign awready_o = awready_q;
  assign wready_o = wready_q;
  assign bvalid_o = bvalid_q;
  assign bresp_o = bresp_q;
  assign arready_o = arready_q;
  assign rvalid_o = rvalid_q;
  assign rdata_o = rdata_q;
  assign rresp_o = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Line-output route decode.

  logic one_se;
  logic two_se;

  assign one_se = mix_one_q[B_MODE];
  assign two_se = mix_two_q[B_MODE];

  // Only routes of the selected mode are passed on; the others are driven low.
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      left_mix_to_pair_one_pos_o <= 1'b0;
      right_mix_to_pair_one_neg_o <= 1'b0;
      left_mix_to_pair_one_neg_o <= 1'b0;
      left_mix_diff_pair_one_o <= 1'b0;
      left_in_one_to_pair_one_o <= 1'b0;
      right_in_one_to_pair_one_o <= 1'b0;
      pair_one_single_ended_o <= 1'b0;
      right_mix_to_pair_two_pos_o <= 1'b0;
      left_mix_to_pair_two_neg_o <= 1'b0;
      right_mix_to_pair_two_neg_o <= 1'b0;
      right_mix_diff_pair_two_o <= 1'b0;
      left_in_one_to_pair_two_o <= 1'b0;
      right_in_one_to_pair_two_o <= 1'b0;
      pair_two_single_ended_o <= 1'b0;
    end
    else
    begin
      pair_one_single_ended_o <= one_se;
      left_mix_to_pair_one_pos_o <= one_se & mix_one_q[B_MIX_MAIN];
      right_mix_to_pair_one_neg_o <= one_se & mix_one_q[B_SE_NEG_B];
      left_mix_to_pair_one_neg_o <= one_se & mix_one_q[B_SE_NEG_A];
      left_mix_diff_pair_one_o <= ~one_se & mix_one_q[B_MIX_MAIN];
      right_in_one_to_pair_one_o <= ~one_se & mix_one_q[B_DIFF_IN_A];
      left_in_one_to_pair_one_o <= ~one_se & mix_one_q[B_DIFF_IN_B];
      pair_two_single_ended_o <= two_se;
      right_mix_to_pair_two_pos_o <= two_se & mix_two_q[B_MIX_MAIN];
      right_mix_to_pair_two_neg_o <= two_se & mix_two_q[B_SE_NEG_A];
      left_mix_to_pair_two_neg_o <= two_se & mix_two_q[B_SE_NEG_B];
      right_mix_diff_pair_two_o <= ~two_se & mix_two_q[B_MIX_MAIN];
      left_in_one_to_pair_two_o <= ~two_se & mix_two_q[B_DIFF_IN_A];
      right_in_one_to_pair_two_o <= ~two_se & mix_two_q[B_DIFF_IN_B];
    end
  end

  // Mutes and attenuation come straight from the volume register.
  assign pair_one_neg_mute_o = vol_q[B_ONE_NEG_MUTE];
  assign pair_one_pos_mute_o = vol_q[B_ONE_POS_MUTE];
  assign pair_one_atten_o = vol_q[B_ONE_ATTEN];
  assign pair_two_neg_mute_o = vol_q[B_TWO_NEG_MUTE];
  assign pair_two_pos_mute_o = vol_q[B_TWO_POS_MUTE];
  assign pair_two_atten_o = vol_q[B_TWO_ATTEN];

  ////////////////////////////////////////////////////////////////////////////
  // Charge pump control.

  logic pump_on;
  logic dyn_sel;
  logic [5:0] vol_max;
  logic [5:0] env_level;
  logic [5:0] drive_level;

  assign pump_on = pump_en_q[B_PUMP_EN];
  assign dyn_sel = env_q[B_DYN_SEL];
  assign vol_max = (hp_left_volume_i > hp_right_volume_i) ? hp_left_volume_i
    : hp_right_volume_i;
  // Reserved source codes fall back to interface one.
  assign env_level = (env_q[B_ENV_SRC_LO +: 2] == ENV_SRC_IF_TWO) ? audio_if_two_level_i
    : audio_if_one_level_i;
  assign drive_level = dyn_sel ? env_level : vol_max;

  // Operating level, enable and discharge drive.
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pump_en_o <= 1'b0;
      pump_discharge_o <= 1'b0;
      pump_dynamic_o <= 1'b0;
      pump_level_o <= 2'h0;
    end
    else
    begin
      pump_en_o <= pump_on;
      pump_discharge_o <= ~pump_on & pump_disch_q[B_PUMP_DISCH];
      pump_dynamic_o <= dyn_sel;
      if (!pump_on)
      begin
        pump_level_o <= 2'h0;
      end
      else if (drive_level >= LEVEL_HIGH_THRESH)
      begin
        pump_level_o <= 2'h2;
      end
      else if (drive_level >= LEVEL_MID_THRESH)
      begin
        pump_level_o <= 2'h1;
      end
      else
      begin
        pump_level_o <= 2'h0;
      end
    end
  end

  // Switching clock runs only while the pump is enabled.
  pump_clock_divider #(
    .HALF_CYCLES(PUMP_HALF_CYCLES)
  ) u_pump_clk (
    .clk_i(clk_i),
    .reset_n_i(rst_n_q),
    .run_i(pump_on),
    .pump_clk_o(pump_clk_o)
  );
endmodule // line_out_mixer_charge_pump_ctrl

// *** hdl/line_out_mixer_pkg.sv ***
// Constants for the line-output mixer and headphone pump control bank.
// Assumes a 10 MHz system clock and an AXI4-Lite master with 32-bit data.
// Notes on behaviour
// - Pair one is single-ended at mode 1, differential at 0; resets differential.
// - Single-ended pair one: left to pos, right to neg, left to neg.
// - Differential pair one: left mixer, left input one, right input one.
// - Pair one attenuation 0 gives 0dB, 1 gives -6dB, both legs, reset 0.
// - Volume register bit 6 mutes pair one neg, bit 5 pos; reset muted.
// - Mixer one bit 0: differential left mixer, or single-ended positive leg.
// - Mixer one bits 6,5,4,2,1 hold routes and mode; all reset 0.
// - Pair two is single-ended at mode 1, differential at 0; resets differential.
// - Single-ended pair two: right to pos, left to neg, right to neg.
// - Differential pair two: right mixer, left input one, right input one.
// - Volume bits 2,1 mute pair two neg, pos (reset 1); bit 0 attenuates.
// - Mixer two bits 6,5,4,2,1,0 hold pair two routes and mode.
// - Pump register one bit 15 enables the headphone pump; reset 0.
// - Dynamic select 0 uses headphone volumes, 1 uses live audio level.
// - Bits 9:8 pick envelope source: 00 interface one, 10 interface two.
// - After reset the pump follows the volume fields.
// - Pump register two bit 15: 1 discharges outputs when off; reset 1.
// - Pump switching clock is divided from the system clock automatically.
// - Envelope register bit 0 is the dynamic select, reset 0.
package line_out_mixer_pkg;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned REG_W = 16;
  // Register indices; byte address is four times the index.
  localparam logic [6:0] IDX_LINE_OUTPUT_VOLUME = 7'h1e;
  localparam logic [6:0] IDX_LINE_MIXER_ONE = 7'h34;
  localparam logic [6:0] IDX_LINE_MIXER_TWO = 7'h35;
  localparam logic [6:0] IDX_PUMP_ENABLE_CTRL = 7'h4c;
  localparam logic [6:0] IDX_PUMP_DISCHARGE_CTRL = 7'h4d;
  localparam logic [6:0] IDX_ENVELOPE_TRACKING_CTRL = 7'h51;
  // Field positions in the volume register.
  localparam int unsigned B_ONE_NEG_MUTE = 6;
  localparam int unsigned B_ONE_POS_MUTE = 5;
  localparam int unsigned B_ONE_ATTEN = 4;
  localparam int unsigned B_TWO_NEG_MUTE = 2;
  localparam int unsigned B_TWO_POS_MUTE = 1;
  localparam int unsigned B_TWO_ATTEN = 0;
  // Field positions shared by both line-mixer registers.
  localparam int unsigned B_SE_NEG_A = 6;
  localparam int unsigned B_SE_NEG_B = 5;
  localparam int unsigned B_MODE = 4;
  localparam int unsigned B_DIFF_IN_A = 2;
  localparam int unsigned B_DIFF_IN_B = 1;
  localparam int unsigned B_MIX_MAIN = 0;
  // Pump fields.
  localparam int unsigned B_PUMP_EN = 15;
  localparam int unsigned B_PUMP_DISCH = 15;
  localparam int unsigned B_ENV_SRC_LO = 8;
  localparam int unsigned B_DYN_SEL = 0;
  // Writable masks and reset values.
  localparam logic [15:0] MASK_VOLUME = 16'h0077;
  localparam logic [15:0] MASK_MIXER = 16'h0077;
  localparam logic [15:0] MASK_PUMP = 16'h8000;
  localparam logic [15:0] MASK_ENVELOPE = 16'h0301;
  localparam logic [15:0] RST_VOLUME = 16'h0066;
  localparam logic [15:0] RST_MIXER = 16'h0000;
  localparam logic [15:0] RST_PUMP_EN = 16'h0000;
  localparam logic [15:0] RST_PUMP_DISCH = 16'h8000;
  localparam logic [15:0] RST_ENVELOPE = 16'h0000;
  // Envelope source codes.
  localparam logic [1:0] ENV_SRC_IF_ONE = 2'h0;
  localparam logic [1:0] ENV_SRC_IF_TWO = 2'h2;
  // Volume or level thresholds for the pump operating level.
  localparam logic [5:0] LEVEL_MID_THRESH = 6'h2d;
  localparam logic [5:0] LEVEL_HIGH_THRESH = 6'h39;
  // Pump clock: system rate and switching rate give the half period.
  localparam int unsigned SYS_CLK_HZ = 10000000;
  localparam int unsigned PUMP_CLK_HZ = 500000;
  localparam int unsigned PUMP_HALF_CYCLES = SYS_CLK_HZ / (2 * PUMP_CLK_HZ);
  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hdl/pump_clock_divider.sv ***
// Divider that makes the pump switching clock from the system clock.
// Assumes an active-low reset from the top module, asserted at once and released synchronously.
`timescale 1ns/1ps
module pump_clock_divider #(
  parameter int unsigned HALF_CYCLES = line_out_mixer_pkg::PUMP_HALF_CYCLES
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Control and output.
  input wire logic run_i,
  output logic pump_clk_o
);
  import line_out_mixer_pkg::*;

  localparam int unsigned CNT_W = $clog2(HALF_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF_CYCLES - 1);

  logic [CNT_W-1:0] count_q;
  logic pump_clk_q;

  // Toggle every half period while running; park low when stopped.
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      count_q <= '0;
      pump_clk_q <= 1'b0;
    end
    else if (!run_i)
    begin
      count_q <= '0;
      pump_clk_q <= 1'b0;
    end
    else if (count_q == CNT_LAST)
    begin
      count_q <= '0;
      pump_clk_q <= ~pump_clk_q;
    end
    else
    begin
      count_q <= count_q + 1'b1;
    end
  end

  assign pump_clk_o = pump_clk_q;
endmodule // pump_clock_divider

// *** tb/line_out_mixer_charge_pump_ctrl_tb.sv ***
// Self-checking bench for the line-output and pump control bank.
// Assumes the design package and the bound checker are compiled first.
`timescale 1ns/1ps
module line_out_mixer_charge_pump_ctrl_tb;
  logic clk_i, reset_n_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic [8:0] awaddr_i, araddr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [3:0] wstrb_i;
  logic [1:0] bresp_o, rresp_o, pump_level_o, rsp;
  logic [5:0] hp_left_volume_i, hp_right_volume_i, audio_if_one_level_i, audio_if_two_level_i;
  logic left_mix_to_pair_one_pos_o, right_mix_to_pair_one_neg_o, left_mix_to_pair_one_neg_o;
  logic left_mix_diff_pair_one_o, left_in_one_to_pair_one_o, right_in_one_to_pair_one_o;
  logic pair_one_single_ended_o, pair_one_neg_mute_o, pair_one_pos_mute_o, pair_one_atten_o;
  logic right_mix_to_pair_two_pos_o, left_mix_to_pair_two_neg_o, right_mix_to_pair_two_neg_o;
  logic right_mix_diff_pair_two_o, left_in_one_to_pair_two_o, right_in_one_to_pair_two_o;
  logic pair_two_single_ended_o, pair_two_neg_mute_o, pair_two_pos_mute_o, pair_two_atten_o;
  logic pump_en_o, pump_discharge_o, pump_dynamic_o, pump_clk_o;
  logic [31:0] rd;
  int n_errors = 0;
  int n_compared = 0;
  int cnt;
  // Register map, writable bits and reset values of the model.
  logic [8:0] addr [6] = '{9'h078, 9'h0d0, 9'h0d4, 9'h130, 9'h134, 9'h144};
  logic [15:0] wmask [6] = '{16'h0077, 16'h0077, 16'h0077, 16'h8000, 16'h8000, 16'h0301};
  logic [15:0] rstv [6] = '{16'h0066, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
  logic [15:0] mdl [6];

  line_out_mixer_charge_pump_ctrl i_dut (.*);

  // Free-running 10 MHz clock.
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////
  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic summarize();
    if (n_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Bus write; index 6 goes to an unmapped word. Updates the model by lanes.
  task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
    logic aw, w;
    logic [15:0] lm;
    @(posedge clk_i);
    {awvalid_i, wvalid_i, bready_i} <= 3'h7;
    awaddr_i <= (i < 6) ? addr[i] : 9'h004;
    wdata_i <= d;
    wstrb_i <= s;
    {aw, w} = 2'h0;
    while (!(aw && w))
    begin
      @(posedge clk_i);
      aw = aw | awready_o;
      w = w | wready_o;
      if (aw) awvalid_i <= 1'b0;
      if (w) wvalid_i <= 1'b0;
    end
    do @(posedge clk_i); while (bvalid_o !== 1'b1);
    rsp = bresp_o;
    bready_i <= 1'b0;
    lm = {{8{s[1]}}, {8{s[0]}}};
    if (i < 6) mdl[i] = (mdl[i] & ~lm) | (d[15:0] & lm & wmask[i]);
  endtask

  // Bus read; data and response land in rd and rsp.
  task automatic rdr(input logic [8:0] a);
    @(posedge clk_i);
    {arvalid_i, rready_i} <= 2'h3;
    araddr_i <= a;
    do @(posedge clk_i); while (arready_o !== 1'b1);
    arvalid_i <= 1'b0;
    do @(posedge clk_i); while (rvalid_o !== 1'b1);
    rd = rdata_o;
    rsp = rresp_o;
    rready_i <= 1'b0;
  endtask

  // Reads every register back against the model.
  task automatic chk_regs();
    for (int i = 0; i < 6; i++)
    begin
      rdr(addr[i]);
      check("reg_read", {rsp, rd}, {2'h0, 16'h0, mdl[i]});
    end
  endtask

  // Compares every decoded output with the model.
  task automatic chk_outs();
    logic [15:0] v, a, b, e;
    logic [5:0] lv;
    logic [1:0] lvl;
    logic [47:0] x, y;
    {v, a, b, e} = {mdl[0], mdl[1], mdl[2], mdl[5]};
    repeat (3) @(posedge clk_i);
    x = {pair_one_single_ended_o, left_mix_to_pair_one_pos_o, right_mix_to_pair_one_neg_o,
      left_mix_to_pair_one_neg_o, left_mix_diff_pair_one_o, left_in_one_to_pair_one_o,
      right_in_one_to_pair_one_o};
    y = {a[4], a[4] & a[0], a[4] & a[5], a[4] & a[6], ~a[4] & a[0], ~a[4] & a[1], ~a[4] & a[2]};
    check("pair_one", x, y);
    x = {pair_two_single_ended_o, right_mix_to_pair_two_pos_o, right_mix_to_pair_two_neg_o,
      left_mix_to_pair_two_neg_o, right_mix_diff_pair_two_o, left_in_one_to_pair_two_o,
      right_in_one_to_pair_two_o};
    y = {b[4], b[4] & b[0], b[4] & b[6], b[4] & b[5], ~b[4] & b[0], ~b[4] & b[2], ~b[4] & b[1]};
    check("pair_two", x, y);
    x = {pair_one_neg_mute_o, pair_one_pos_mute_o, pair_one_atten_o, pair_two_neg_mute_o,
      pair_two_pos_mute_o, pair_two_atten_o};
    check("volume", x, {v[6], v[5], v[4], v[2], v[1], v[0]});
    lv = (hp_left_volume_i > hp_right_volume_i) ? hp_left_volume_i : hp_right_volume_i;
    if (e[0]) lv = (e[9:8] == 2'h2) ? audio_if_two_level_i : audio_if_one_level_i;
    lvl = (lv >= 6'h39) ? 2'h2 : (lv >= 6'h2d) ? 2'h1 : 2'h0;
    x = {pump_en_o, pump_discharge_o, pump_dynamic_o, pump_level_o};
    y = {mdl[3][15], ~mdl[3][15] & mdl[4][15], e[0], mdl[3][15] ? lvl : 2'h0};
    check("pump", x, y);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = 5'h0;
    {awaddr_i, araddr_i, wdata_i, wstrb_i} = '0;
    {hp_left_volume_i, hp_right_volume_i, audio_if_one_level_i, audio_if_two_level_i} = '0;
    reset_n_i = 1'b0;
    void'($urandom(32'h8783));
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    mdl = rstv;
    chk_outs();
    chk_regs();
    rdr(9'h000);
    check("unmapped_read", {rsp, rd}, {2'h2, 32'h0});
    wr(6, 32'hffffffff, 4'hf);
    check("unmapped_write", rsp, 2'h2);
    // Single-ended modes; the mid-rail buffer enable lives outside this bank.
    for (int i = 0; i < 6; i++) wr(i, 32'hffffffff, 4'hf);
    chk_regs();
    chk_outs();
    // Every envelope source code with level-driven control.
    {audio_if_one_level_i, audio_if_two_level_i} <= {6'h3f, 6'h30};
    for (int k = 0; k < 4; k++)
    begin
      wr(5, 32'h1 | (k << 8), 4'hf);
      chk_outs();
    end
    // Half period of the pump clock while enabled.
    do @(posedge clk_i); while (pump_clk_o !== 1'b1);
    do @(posedge clk_i); while (pump_clk_o !== 1'b0);
    cnt = 0;
    do
    begin
      @(posedge clk_i);
      cnt++;
    end
    while (pump_clk_o !== 1'b1 && cnt < 100);
    check("pump_half", cnt, 10);
    // Random writes with random lanes and level inputs.
    for (int n = 0; n < 60; n++)
    begin
      {hp_left_volume_i, hp_right_volume_i, audio_if_one_level_i, audio_if_two_level_i} <=
        24'($urandom);
      wr($urandom % 6, $urandom, 4'($urandom));
      check("write_resp", rsp, 2'h0);
      chk_outs();
      chk_regs();
    end
    // Reset in mid-run restores every default.
    reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    mdl = rstv;
    chk_outs();
    chk_regs();
    summarize();
  end

  // Cuts a hang short.
  initial
  begin
    repeat (30000) @(posedge clk_i);
    n_errors++;
    summarize();
  end
endmodule // line_out_mixer_charge_pump_ctrl_tb

// *** tb/line_out_mixer_checker.sv ***
// Concurrent checks on the ports of the line-output and pump control bank.
// Assumes binding to the top module and a single clock domain.
`timescale 1ns/1ps
module line_out_mixer_checker (
  // Clock, reset and bus.
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic awvalid_i,
  input wire logic awready_o,
  input wire logic wvalid_i,
  input wire logic wready_o,
  input wire logic bvalid_o,
  input wire logic bready_i,
  input wire logic [1:0] bresp_o,
  input wire logic arvalid_i,
  input wire logic arready_o,
  input wire logic rvalid_o,
  input wire logic [31:0] rdata_o,
  // Routes.
  input wire logic pair_one_single_ended_o,
  input wire logic left_mix_to_pair_one_pos_o,
  input wire logic right_mix_to_pair_one_neg_o,
  input wire logic left_mix_to_pair_one_neg_o,
  input wire logic left_mix_diff_pair_one_o,
  input wire logic left_in_one_to_pair_one_o,
  input wire logic right_in_one_to_pair_one_o,
  input wire logic pair_two_single_ended_o,
  input wire logic right_mix_to_pair_two_pos_o,
  input wire logic left_mix_to_pair_two_neg_o,
  input wire logic right_mix_to_pair_two_neg_o,
  // Mutes and attenuation.
  input wire logic pair_one_neg_mute_o,
  input wire logic pair_one_pos_mute_o,
  input wire logic pair_one_atten_o,
  input wire logic pair_two_neg_mute_o,
  input wire logic pair_two_pos_mute_o,
  input wire logic pair_two_atten_o,
  // Pump.
  input wire logic pump_en_o,
  input wire logic pump_discharge_o,
  input wire logic [1:0] pump_level_o,
  input wire logic pump_clk_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////
  // Routes of the mode not selected give no path: both modes of pair one, single-ended of pair two.
  chk_one_se_gate:
  assert property (!pair_one_single_ended_o |-> !(left_mix_to_pair_one_pos_o
    || right_mix_to_pair_one_neg_o || left_mix_to_pair_one_neg_o)) else $error("pair one se leak");
  chk_one_diff_gate:
  assert property (pair_one_single_ended_o |-> !(left_mix_diff_pair_one_o
    || left_in_one_to_pair_one_o || right_in_one_to_pair_one_o)) else $error("pair one diff leak");
  chk_two_se_gate:
  assert property (!pair_two_single_ended_o |-> !(right_mix_to_pair_two_pos_o
    || left_mix_to_pair_two_neg_o || right_mix_to_pair_two_neg_o)) else $error("pair two se leak");
  // Leaving reset the legs are muted and not attenuated.
  chk_reset_mutes:
  assert property ($rose(reset_n_i) |-> pair_one_neg_mute_o && pair_one_pos_mute_o
    && pair_two_neg_mute_o && pair_two_pos_mute_o && !pair_one_atten_o && !pair_two_atten_o)
    else $error("mute reset wrong");
  // Pump discharge, level and clock follow the enable.
  chk_disch_excl:
  assert property (pump_en_o |-> !pump_discharge_o) else $error("discharge while enabled");
  chk_level_off:
  assert property (!pump_en_o [*2] |-> pump_level_o == 2'h0) else $error("level while off");
  chk_clk_idle:
  assert property (!pump_en_o [*3] |-> !pump_clk_o) else $error("pump clock while off");
  chk_clk_half:
  assert property ($rose(pump_clk_o) |=> ($stable(pump_clk_o) || !pump_en_o) [*8])
    else $error("pump clock half period short");
  // Bus answers.
  chk_b_answer:
  assert property (awvalid_i && awready_o && wvalid_i && wready_o |-> ##[1:3] bvalid_o)
    else $error("write response late");
  chk_b_stand:
  assert property (bvalid_o && bready_i |=> !bvalid_o) else $error("write response stuck");
  chk_r_answer:
  assert property (arvalid_i && arready_o |=> rvalid_o && rdata_o[31:16] == 16'h0)
    else $error("read answer wrong");
  // Main scenarios reached.
  cover property (bvalid_o && bready_i && bresp_o == 2'h2);
  cover property (pair_one_single_ended_o && left_mix_to_pair_one_neg_o);
  cover property (pump_en_o && pump_clk_o && pump_level_o == 2'h2);
endmodule // line_out_mixer_checker

bind line_out_mixer_charge_pump_ctrl line_out_mixer_checker i_checker (.*);
